//--- design/i2c_slave_register_port.sv
`timescale 1ns/1ps
`include "i2c_port_regs.svh"
// Contract
// - Runs at 100 kHz and 400 kHz
// - Pulses under 50 ns are ignored
// - Slave only, never drives the clock
// - Answers only its own slave address
// - Address byte: 7 bits, then direction
// - Data changes only while clock low
// - Data edges during clock high: start, stop
// - Bytes are eight bits, MSB first
// - Acknowledge pulls data low, ninth clock
// - Released data in ninth clock: no acknowledge
// - Matched address acknowledged, direction then followed
// - Two write bytes form register address
// - No limit on bytes per transaction
// - Reads start at held register address
// - Read ends on master's no acknowledge
// - Start or stop aborts any byte
// - Address-only write just loads the pointer
// - Repeated start allows combined write-read
// - Update bit write pulses, then self-clears
// - Read copy selected by select bit
// - Denied access reads zero, ignores writes
module i2c_slave_register_port
    import i2c_port_pkg::*;
#(
    parameter logic [6:0] BASE_ADDR = `SLAVE_BASE_ADDR
) (
    input  wire logic        CORE_CLK,
    input  wire logic        RESETN,
    input  wire logic        CE,
    input  wire logic        LINK_CLK,
    input  wire logic        SCL_IN,
    input  wire logic        SDA_IN,
    output logic             SDA_OUT,
    output logic             SDA_OE,
    input  wire logic [2:0]  ADDR_SEL,
    output logic [15:0]      REG_ADDR,
    output logic [7:0]       REG_WDATA,
    output logic             REG_WR_STB,
    output logic             REG_RD_STB,
    input  wire logic [7:0]  REG_RDATA,
    input  wire logic        REG_DENY,
    output logic             REG_RD_ACTIVE,
    output logic             IO_UPDATE
);

    function automatic logic [6:0] slave_addr(input logic [6:0] base, input logic [2:0] sel);
        logic [2:0] idx;
        idx = (sel > 3'(`SLAVE_COUNT - 1)) ? 3'(`SLAVE_COUNT - 1) : sel;
        return base + {4'h0, idx};
    endfunction : slave_addr

    function automatic logic [15:0] bump(input logic [15:0] p);
        return p + 16'h0001;
    endfunction : bump

    function automatic access_req_t make_req(input logic wr, input logic [15:0] a, input logic [7:0] d);
        access_req_t r;
        r.wr   = wr;
        r.addr = a;
        r.data = d;
        return r;
    endfunction : make_req

    // Link domain signals
    logic        link_rst_m;
    logic        link_rst_n;
    logic        ce_m;
    logic        ce_l;
    logic [2:0]  sel_m;
    logic [2:0]  sel_s;
    logic        scl_f;
    logic        sda_f;
    logic        scl_q;
    logic        sda_q;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_det;
    logic        stop_det;
    logic [6:0]  own_addr;
    link_state_t state;
    logic [3:0]  bit_cnt;
    logic [7:0]  shift;
    logic [7:0]  tx;
    logic [7:0]  addr_hi;
    logic [15:0] ptr;
    logic        rd_dir;
    logic        req_tgl;
    access_req_t req_q;
    logic        ack_m;
    logic        ack_s;
    logic        ack_q;
    logic        busy;
    logic [7:0]  rd_buf;

    // Core domain signals
    logic        req_m;
    logic        req_s;
    logic        req_p;
    logic        new_req;
    core_state_t cstate;
    logic        wr_q;
    logic        ack_tgl;
    logic [7:0]  rd_data;

    // Link reset release and enable crossing
    always_ff @(posedge LINK_CLK or negedge RESETN) begin
        if (!RESETN) begin
            link_rst_m <= 1'h0;
            link_rst_n <= 1'h0;
        end else begin
            link_rst_m <= 1'h1;
            link_rst_n <= link_rst_m;
        end
    end

    always_ff @(posedge LINK_CLK or negedge link_rst_n) begin
        if (!link_rst_n) begin
            ce_m <= 1'h0;
            ce_l <= 1'h0;
        end else begin
            ce_m <= CE;
            ce_l <= ce_m;
        end
    end

    always_ff @(posedge LINK_CLK or negedge link_rst_n) begin
        if (!link_rst_n) begin
            sel_m <= 3'h0;
            sel_s <= 3'h0;
        end else if (ce_l) begin
            sel_m <= ADDR_SEL;
            sel_s <= sel_m;
        end
    end

    assign own_addr = slave_addr(BASE_ADDR, sel_s);

    // Oversampled, spike-filtered bus lines
    i2c_line_filter #(.STABLE(`SPIKE_CYCLES)) scl_filter (
        .clk   (LINK_CLK),
        .rst_n (link_rst_n),
        .ce    (ce_l),
        .pin   (SCL_IN),
        .level (scl_f)
    );

    i2c_line_filter #(.STABLE(`SPIKE_CYCLES)) sda_filter (
        .clk   (LINK_CLK),
        .rst_n (link_rst_n),
        .ce    (ce_l),
        .pin   (SDA_IN),
        .level (sda_f)
    );

    always_ff @(posedge LINK_CLK or negedge link_rst_n) begin
        if (!link_rst_n) begin
            scl_q <= 1'h1;
            sda_q <= 1'h1;
        end else if (ce_l) begin
            scl_q <= scl_f;
            sda_q <= sda_f;
        end
    end

    assign scl_rise  = scl_f & ~scl_q;
    assign scl_fall  = ~scl_f & scl_q;
    assign start_det = scl_f & scl_q & sda_q & ~sda_f;
    assign stop_det  = scl_f & scl_q & ~sda_q & sda_f;
    assign busy      = req_tgl ^ ack_q;

    // Only the data line is ever driven, and only low
    always_ff @(posedge LINK_CLK or negedge link_rst_n) begin
        if (!link_rst_n) begin
            SDA_OUT <= 1'h0;
        end else begin
            SDA_OUT <= 1'h0;
        end
    end

    // Bus engine
    always_ff @(posedge LINK_CLK or negedge link_rst_n) begin
        if (!link_rst_n) begin
            state   <= LS_IDLE;
            bit_cnt <= 4'h0;
            shift   <= 8'h00;
            tx      <= 8'h00;
            addr_hi <= 8'h00;
            ptr     <= 16'h0000;
            rd_dir  <= 1'h0;
            SDA_OE  <= 1'h0;
            req_tgl <= 1'h0;
            req_q   <= '0;
        end else if (ce_l) begin
            if (start_det) begin
                state   <= LS_ADDR;
                bit_cnt <= 4'h0;
                SDA_OE  <= 1'h0;
            end else if (stop_det) begin
                state   <= LS_IDLE;
                bit_cnt <= 4'h0;
                SDA_OE  <= 1'h0;
            end else if (state != LS_IDLE && scl_rise) begin
                if (bit_cnt < `BYTE_BITS) begin
                    shift <= {shift[6:0], sda_f};
                end
                if (state == LS_RDATA && bit_cnt == `ACK_SLOT && sda_f) begin
                    state   <= LS_IDLE;
                    bit_cnt <= 4'h0;
                end else begin
                    bit_cnt <= bit_cnt + 4'h1;
                end
            end else if (state != LS_IDLE && scl_fall) begin
                if (bit_cnt == `ACK_SLOT) begin
                    unique case (state)
                        LS_ADDR: begin
                            if (shift[7:1] == own_addr) begin
                                SDA_OE <= 1'h1;
                                rd_dir <= shift[0];
                                if (shift[0] && !busy) begin
                                    req_q   <= make_req(1'h0, ptr, 8'h00);
                                    req_tgl <= ~req_tgl;
                                end
                            end else begin
                                state <= LS_IDLE;
                            end
                        end
                        LS_REGH: begin
                            addr_hi <= shift;
                            SDA_OE  <= 1'h1;
                        end
                        LS_REGL: begin
                            ptr    <= {addr_hi, shift};
                            SDA_OE <= 1'h1;
                        end
                        LS_WDATA: begin
                            if (!busy) begin
                                req_q   <= make_req(1'h1, ptr, shift);
                                req_tgl <= ~req_tgl;
                            end
                            ptr    <= bump(ptr);
                            SDA_OE <= 1'h1;
                        end
                        LS_RDATA: begin
                            SDA_OE <= 1'h0;
                        end
                        default: begin
                            state <= LS_IDLE;
                        end
                    endcase
                end else if (bit_cnt == `ACK_END) begin
                    bit_cnt <= 4'h0;
                    SDA_OE  <= 1'h0;
                    if (state == LS_RDATA || (state == LS_ADDR && rd_dir)) begin
                        state  <= LS_RDATA;
                        tx     <= rd_buf;
                        SDA_OE <= ~rd_buf[7];
                        ptr    <= bump(ptr);
                        if (!busy) begin
                            req_q   <= make_req(1'h0, bump(ptr), 8'h00);
                            req_tgl <= ~req_tgl;
                        end
                    end else if (state == LS_ADDR) begin
                        state <= LS_REGH;
                    end else if (state == LS_REGH) begin
                        state <= LS_REGL;
                    end else if (state == LS_REGL) begin
                        state <= LS_WDATA;
                    end
                end else if (state == LS_RDATA) begin
                    tx     <= {tx[6:0], 1'h0};
                    SDA_OE <= ~tx[6];
                end
            end
        end
    end

    // Read data returning from the core domain
    always_ff @(posedge LINK_CLK or negedge link_rst_n) begin
        if (!link_rst_n) begin
            ack_m  <= 1'h0;
            ack_s  <= 1'h0;
            ack_q  <= 1'h0;
            rd_buf <= 8'h00;
        end else if (ce_l) begin
            ack_m <= ack_tgl;
            ack_s <= ack_m;
            ack_q <= ack_s;
            if (ack_s != ack_q) begin
                rd_buf <= rd_data;
            end
        end
    end

    // Request crossing into the core domain
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            req_m <= 1'h0;
            req_s <= 1'h0;
            req_p <= 1'h0;
        end else if (CE) begin
            req_m <= req_tgl;
            req_s <= req_m;
            req_p <= req_s;
        end
    end

    assign new_req = req_s ^ req_p;

    // Register access sequencer
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            cstate     <= CS_IDLE;
            wr_q       <= 1'h0;
            REG_ADDR   <= 16'h0000;
            REG_WDATA  <= 8'h00;
            REG_WR_STB <= 1'h0;
            REG_RD_STB <= 1'h0;
            IO_UPDATE  <= 1'h0;
            ack_tgl    <= 1'h0;
            rd_data    <= 8'h00;
        end else if (CE) begin
            REG_WR_STB <= 1'h0;
            REG_RD_STB <= 1'h0;
            IO_UPDATE  <= 1'h0;
            unique case (cstate)
                CS_IDLE: begin
                    if (new_req) begin
                        REG_ADDR  <= req_q.addr;
                        REG_WDATA <= req_q.data;
                        wr_q      <= req_q.wr;
                        cstate    <= CS_ACCESS;
                    end
                end
                CS_ACCESS: begin
                    cstate  <= CS_IDLE;
                    ack_tgl <= ~ack_tgl;
                    if (wr_q) begin
                        if (!REG_DENY) begin
                            REG_WR_STB <= 1'h1;
                            IO_UPDATE  <= (REG_ADDR == `UPDATE_REG_ADDR) && REG_WDATA[`UPDATE_BIT];
                        end
                    end else begin
                        REG_RD_STB <= 1'h1;
                        rd_data    <= REG_DENY ? `DENIED_READ_VALUE : REG_RDATA;
                    end
                end
                default: begin
                    cstate <= CS_IDLE;
                end
            endcase
        end
    end

    // Buffered or active readback select
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            REG_RD_ACTIVE <= 1'h0;
        end else if (CE && cstate == CS_ACCESS && wr_q && !REG_DENY && REG_ADDR == `READ_SEL_REG_ADDR) begin
            REG_RD_ACTIVE <= REG_WDATA[`READ_SEL_BIT];
        end
    end

    idle_quiet_a: assert property (@(posedge LINK_CLK) disable iff (!link_rst_n || !ce_l)
        state == LS_IDLE |-> !SDA_OE)
        else $error("Data line driven while idle");

    start_abort_a: assert property (@(posedge LINK_CLK) disable iff (!link_rst_n || !ce_l)
        start_det |=> state == LS_ADDR && bit_cnt == 4'h0 && !SDA_OE)
        else $error("Start did not restart address reception");

    stop_idle_a: assert property (@(posedge LINK_CLK) disable iff (!link_rst_n || !ce_l)
        stop_det |=> state == LS_IDLE && !SDA_OE)
        else $error("Stop did not return the port to idle");

    drive_window_a: assert property (@(posedge LINK_CLK) disable iff (!link_rst_n || !ce_l)
        $changed(SDA_OE) && !$past(start_det) && !$past(stop_det) |-> !scl_f)
        else $error("Data drive changed while clock high");

    addr_ack_a: assert property (@(posedge LINK_CLK) disable iff (!link_rst_n || !ce_l)
        state == LS_ADDR && scl_fall && bit_cnt == `ACK_SLOT && shift[7:1] == own_addr && !start_det && !stop_det
        |=> SDA_OE && !SDA_OUT ##1 SDA_OE)
        else $error("Matching address not acknowledged");

    nack_end_a: assert property (@(posedge LINK_CLK) disable iff (!link_rst_n || !ce_l)
        state == LS_RDATA && scl_rise && bit_cnt == `ACK_SLOT && sda_f |=> state == LS_IDLE && !SDA_OE)
        else $error("Read continued after no acknowledge");

    ptr_load_a: assert property (@(posedge LINK_CLK) disable iff (!link_rst_n || !ce_l)
        state == LS_REGL && scl_fall && bit_cnt == `ACK_SLOT && !start_det && !stop_det
        |=> ptr == {$past(addr_hi), $past(shift)})
        else $error("Register address not loaded high byte first");

    ptr_step_a: assert property (@(posedge LINK_CLK) disable iff (!link_rst_n || !ce_l)
        state == LS_WDATA && scl_fall && bit_cnt == `ACK_SLOT && !start_det && !stop_det
        |=> ptr == 16'($past(ptr) + 16'h0001))
        else $error("Pointer did not advance after a write byte");

    deny_write_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN || !CE)
        REG_WR_STB |-> !$past(REG_DENY) && $past(cstate) == CS_ACCESS)
        else $error("Write strobe issued to a denied register");

    deny_read_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN || !CE)
        cstate == CS_ACCESS && !wr_q && REG_DENY |=> rd_data == `DENIED_READ_VALUE)
        else $error("Denied read returned nonzero data");

    update_pulse_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN || !CE)
        IO_UPDATE |-> REG_WR_STB && REG_ADDR == `UPDATE_REG_ADDR && REG_WDATA[`UPDATE_BIT] ##1 !IO_UPDATE)
        else $error("Update pulse wrong or not self-clearing");

    read_sel_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN || !CE)
        REG_WR_STB && REG_ADDR == `READ_SEL_REG_ADDR |-> REG_RD_ACTIVE == REG_WDATA[`READ_SEL_BIT])
        else $error("Readback select not taken from write");

endmodule : i2c_slave_register_port

//--- common/i2c_port_regs.svh
`ifndef I2C_PORT_REGS_SVH
`define I2C_PORT_REGS_SVH

// Register addresses handled inside the port
`define READ_SEL_REG_ADDR   16'h0004
`define UPDATE_REG_ADDR     16'h0005
`define READ_SEL_BIT        0
`define UPDATE_BIT          0
`define DENIED_READ_VALUE   8'h00

// Byte framing on the bus
`define BYTE_BITS           4'h8
`define ACK_SLOT            4'h8
`define ACK_END             4'h9

// Bus rates and spike suppression
`define STD_RATE_KHZ        100
`define FAST_RATE_KHZ       400
`define SPIKE_NS            50
`define LINK_PERIOD_NS      30
`define SPIKE_CYCLES        ((`SPIKE_NS + `LINK_PERIOD_NS - 1) / `LINK_PERIOD_NS)

// Address straps
`define SLAVE_COUNT         7
`define SLAVE_BASE_ADDR     7'h48

`endif

//--- common/i2c_port_pkg.sv
package i2c_port_pkg;

    typedef struct packed {
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  data;
    } access_req_t;

    typedef enum logic [5:0] {
        LS_IDLE  = 6'h01,
        LS_ADDR  = 6'h02,
        LS_REGH  = 6'h04,
        LS_REGL  = 6'h08,
        LS_WDATA = 6'h10,
        LS_RDATA = 6'h20
    } link_state_t;

    typedef enum logic [1:0] {
        CS_IDLE   = 2'h1,
        CS_ACCESS = 2'h2
    } core_state_t;

endpackage : i2c_port_pkg

//--- design/i2c_line_filter.sv
`timescale 1ns/1ps
`include "i2c_port_regs.svh"
module i2c_line_filter #(
    parameter int STABLE = `SPIKE_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic pin,
    output logic      level
);
    localparam int CW = $clog2(STABLE + 1);

    logic          pin_m;
    logic          pin_s;
    logic [CW-1:0] run;

    // Two-stage synchroniser
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_m <= 1'h1;
            pin_s <= 1'h1;
        end else if (ce) begin
            pin_m <= pin;
            pin_s <= pin_m;
        end
    end

    // Level follows only after STABLE+1 agreeing samples
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run   <= '0;
            level <= 1'h1;
        end else if (ce) begin
            if (pin_s == level) begin
                run <= '0;
            end else if (run == CW'(STABLE)) begin
                level <= pin_s;
                run   <= '0;
            end else begin
                run <= run + CW'(1);
            end
        end
    end

    glitch_reject_a: assert property (@(posedge clk) disable iff (!rst_n || !ce)
        $changed(level) |-> level == $past(pin_s) && level == $past(pin_s, 2) && level == $past(pin_s, 3))
        else $error("Filter output changed on a short pulse");

endmodule : i2c_line_filter

//--- tb/i2c_master_model.sv
`timescale 1ns/1ps
module i2c_master_model (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    int q_len = 7;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic q();
        repeat (q_len) @(posedge clk);
    endtask : q
    // Quarter period in clocks: 7 gives about 357 kHz, 25 gives 100 kHz
    task automatic bit_io(input logic b, output logic r);
        sda_low <= ~b;
        q();
        scl <= 1'b1;
        q();
        r = sda;
        q();
        scl <= 1'b0;
        q();
    endtask : bit_io
    task automatic start();
        sda_low <= 1'b0;
        q();
        scl <= 1'b1;
        q();
        sda_low <= 1'b1;
        q();
        scl <= 1'b0;
        q();
    endtask : start
    task automatic stop();
        sda_low <= 1'b1;
        q();
        scl <= 1'b1;
        q();
        sda_low <= 1'b0;
        q();
    endtask : stop
    // Clock pulse too short to count
    task automatic spike();
        q();
        scl <= 1'b1;
        #40;
        scl <= 1'b0;
    endtask : spike
    task automatic wr(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask : wr
    task automatic rd(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(~ack, r);
    endtask : rd
endmodule : i2c_master_model

//--- tb/i2c_slave_register_port_test.sv
`timescale 1ns/1ps
module i2c_slave_register_port_test;
    import i2c_port_pkg::*;
    localparam logic [6:0] DEV = 7'h48 + 7'h03;
    logic core_clk, link_clk, resetn, scl, sda_low, sda, sda_out, sda_oe;
    logic [2:0]  addr_sel;
    logic [15:0] reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, d;
    logic        wr_stb, rd_stb, deny, rd_active, io_update, ack;
    logic [7:0]  mem [0:63];
    int error_cnt, checks_done, cyc_cnt, wr_cnt, upd_cnt, rd_cnt;
    assign sda = ~sda_low & (sda_oe ? sda_out : 1'b1);
    assign deny = reg_addr[15:6] != 10'h000;
    assign reg_rdata = deny ? 8'h5a : mem[reg_addr[5:0]];
    i2c_slave_register_port #(.BASE_ADDR(7'h48)) i_dut (
        .CORE_CLK(core_clk), .RESETN(resetn), .CE(1'b1), .LINK_CLK(link_clk),
        .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
        .ADDR_SEL(addr_sel), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR_STB(wr_stb), .REG_RD_STB(rd_stb), .REG_RDATA(reg_rdata),
        .REG_DENY(deny), .REG_RD_ACTIVE(rd_active), .IO_UPDATE(io_update)
    );
    i2c_master_model m (.clk(core_clk), .sda(sda), .scl(scl), .sda_low(sda_low));
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    initial begin
        link_clk = 1'b0;
        #7;
        forever #15 link_clk = ~link_clk;
    end
    // Register file partner and strobe counters
    always @(posedge core_clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (wr_stb === 1'b1) begin
            mem[reg_addr[5:0]] <= reg_wdata;
            wr_cnt <= wr_cnt + 1;
        end
        if (io_update === 1'b1) upd_cnt <= upd_cnt + 1;
        if (rd_stb === 1'b1) rd_cnt <= rd_cnt + 1;
        if (cyc_cnt == 40000) begin
            error_cnt++;
            test_done();
        end
    end
    task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : cmp8
    task automatic cmp_int(input string n, input int e, input int g);
        checks_done++;
        if (g != e) begin
            error_cnt++;
            $display("[FAIL] %s expected %0d seen %0d", n, e, g);
        end
    endtask : cmp_int
    task automatic test_done();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : test_done
    // Start, device write address, two pointer bytes
    task automatic set_ptr(input logic [15:0] a, input logic fin);
        m.start();
        m.wr({DEV, 1'b0}, ack);
        cmp8("addr ack", 8'h01, {7'h00, ack});
        m.wr(a[15:8], ack);
        cmp8("regh ack", 8'h01, {7'h00, ack});
        m.wr(a[7:0], ack);
        cmp8("regl ack", 8'h01, {7'h00, ack});
        if (fin) m.stop();
    endtask : set_ptr
    task automatic rd_start();
        m.start();
        m.wr({DEV, 1'b1}, ack);
        cmp8("rd addr ack", 8'h01, {7'h00, ack});
    endtask : rd_start
    task automatic s_write();
        int w0;
        w0 = wr_cnt;
        set_ptr(16'h0010, 1'b0);
        m.wr(8'ha5, ack);
        m.wr(8'h3c, ack);
        m.wr(8'h0f, ack);
        cmp8("last data ack", 8'h01, {7'h00, ack});
        m.stop();
        repeat (10) @(posedge core_clk);
        cmp_int("write count", w0 + 3, wr_cnt);
        cmp8("mem10", 8'ha5, mem[16]);
        cmp8("mem11", 8'h3c, mem[17]);
        cmp8("mem12", 8'h0f, mem[18]);
    endtask : s_write
    task automatic s_read();
        int w0, r0;
        w0 = wr_cnt;
        r0 = rd_cnt;
        set_ptr(16'h0011, 1'b1);
        cmp_int("ptr only writes", w0, wr_cnt);
        rd_start();
        m.rd(1'b1, d);
        cmp8("rd 11", 8'h3c, d);
        m.rd(1'b0, d);
        cmp8("rd 12", 8'h0f, d);
        m.stop();
        cmp8("released", 8'h00, {7'h00, sda_oe});
        set_ptr(16'h0010, 1'b0);
        rd_start();
        m.rd(1'b0, d);
        cmp8("combined rd", 8'ha5, d);
        m.stop();
        cmp_int("read strobes", r0 + 5, rd_cnt);
    endtask : s_read
    task automatic s_wrong();
        m.start();
        m.wr({7'h4a, 1'b0}, ack);
        cmp8("foreign ack", 8'h00, {7'h00, ack});
        m.stop();
    endtask : s_wrong
    task automatic s_deny();
        int w0;
        w0 = wr_cnt;
        set_ptr(16'h0100, 1'b0);
        m.wr(8'h77, ack);
        m.stop();
        repeat (10) @(posedge core_clk);
        cmp_int("denied write", w0, wr_cnt);
        set_ptr(16'h0100, 1'b0);
        rd_start();
        m.rd(1'b0, d);
        cmp8("denied rd", 8'h00, d);
        m.stop();
    endtask : s_deny
    task automatic s_update();
        int u0;
        u0 = upd_cnt;
        set_ptr(16'h0004, 1'b0);
        m.wr(8'h01, ack);
        m.wr(8'h01, ack);
        m.stop();
        repeat (10) @(posedge core_clk);
        cmp8("read select", 8'h01, {7'h00, rd_active});
        cmp_int("update pulses", u0 + 1, upd_cnt);
    endtask : s_update
    task automatic s_abort();
        int w0;
        logic r;
        w0 = wr_cnt;
        set_ptr(16'h0012, 1'b0);
        for (int i = 0; i < 4; i++) m.bit_io(1'b0, r);
        m.stop();
        repeat (10) @(posedge core_clk);
        cmp_int("aborted byte", w0, wr_cnt);
        cmp8("mem12 kept", 8'h0f, mem[18]);
    endtask : s_abort
    task automatic s_spike();
        set_ptr(16'h0014, 1'b0);
        m.spike();
        m.wr(8'h5e, ack);
        m.stop();
        repeat (10) @(posedge core_clk);
        cmp8("spike data", 8'h5e, mem[20]);
    endtask : s_spike
    task automatic s_slow();
        m.q_len = 25;
        set_ptr(16'h0020, 1'b0);
        m.wr(8'h96, ack);
        cmp8("slow data ack", 8'h01, {7'h00, ack});
        m.stop();
        set_ptr(16'h0020, 1'b0);
        rd_start();
        m.rd(1'b0, d);
        cmp8("slow rd", 8'h96, d);
        m.stop();
        m.q_len = 7;
    endtask : s_slow
    initial begin
        resetn = 1'b0;
        addr_sel = 3'h3;
        error_cnt = 0;
        checks_done = 0;
        cyc_cnt = 0;
        wr_cnt = 0;
        upd_cnt = 0;
        rd_cnt = 0;
        for (int i = 0; i < 64; i++) mem[i] = 8'h00;
        repeat (20) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (10) @(posedge core_clk);
        s_write();
        s_read();
        s_wrong();
        s_deny();
        s_update();
        s_abort();
        s_spike();
        s_slow();
        test_done();
    end
endmodule : i2c_slave_register_port_test
